// ### rtl/flb_pkg.sv
// ==========================================================
// shared constants for the loop bypass and signal detect block
package flb_pkg;
    // apb register map, byte addresses of aligned words
    localparam int unsigned FLB_AW = 12;
    localparam logic [11:0] FLB_CTRL_OFS = 12'h000;
    localparam logic [11:0] FLB_STATUS_OFS = 12'h004;
    // control register fields
    localparam int unsigned FLB_CTRL_W = 4;
    localparam int unsigned FLB_CTRL_MODE_BIT = 0;
    localparam int unsigned FLB_CTRL_P1_BIT = 1;
    localparam int unsigned FLB_CTRL_P2_BIT = 2;
    localparam int unsigned FLB_CTRL_RATE_BIT = 3;
    localparam logic [3:0] FLB_CTRL_RST = 4'h8;
    // status register fields
    localparam int unsigned FLB_ST_BAD_LSB = 0;
    localparam int unsigned FLB_ST_ERR_LSB = 2;
    localparam int unsigned FLB_ST_REF_LSB = 4;
    localparam int unsigned FLB_ST_RATE_BIT = 6;
    // bit clock multiplication factors per reference rate
    localparam logic [4:0] FLB_RATIO_HIGH = 5'h0A;
    localparam logic [4:0] FLB_RATIO_LOW = 5'h14;
    // signal detect figures
    localparam logic [2:0] FLB_RUN_LIMIT = 3'h5;
    localparam logic [6:0] FLB_COMMA_POS = 7'h05;
    localparam logic [6:0] FLB_COMMA_NEG = 7'h7A;
    localparam int unsigned FLB_INTERVAL_BITS = 32768;
    localparam logic [2:0] FLB_CONSEC_N = 3'h4;
    // bit times without a transition before a retimer falls back on the reference
    localparam logic [6:0] FLB_QUIET_BITS = 7'h40;
    // failure output state
    typedef enum logic {FLB_LINK_GOOD, FLB_LINK_BAD} flb_link_state_type;
endpackage

// ### rtl/flb_bypass_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one bypass stage: insert the drive or skip it, one bit per pclk
module flb_bypass_stage (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic loop_in,
    input wire logic drive_serial_in,
    input wire logic drive_insert_select,
    output logic drive_serial_out,
    output logic loop_out
);
    // registered so a closed ring of stages never forms a combinational loop
    typedef struct packed {
        logic fwd;
        logic out;
    } flb_stage_type;

    flb_stage_type q, d;

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.fwd = loop_in;
        if (drive_insert_select) begin
            d.out = drive_serial_in;
        end else begin
            d.out = loop_in;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign drive_serial_out = q.fwd;
    assign loop_out = q.out;
endmodule // flb_bypass_stage
`default_nettype wire

// ### rtl/flb_signal_detect.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// signal detect unit: run length and comma checks over fixed intervals
module flb_signal_detect #(
    parameter int unsigned INTERVAL_BITS = flb_pkg::FLB_INTERVAL_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_in,
    input wire logic error_mode_pick,
    output logic link_bad_n,
    output logic interval_err
);
    import flb_pkg::*;
    localparam int unsigned CW = $clog2(INTERVAL_BITS);
    localparam logic [CW-1:0] LAST = CW'(INTERVAL_BITS - 1);

    // all state of the unit; nothing is shared with the other unit
    typedef struct packed {
        logic prev_bit;
        logic [2:0] run_cnt; // saturates, only compared with the limit
        logic [6:0] shift; // last seven bits, newest in bit 0
        logic [CW-1:0] ivl_cnt; // bit position inside the interval
        logic run_seen; // run violation seen this interval
        logic comma_seen; // comma seen this interval
        logic last_err; // result of the interval just closed
        flb_link_state_type state;
        logic [2:0] consec; // intervals in a row against the state
        logic bad_n;
    } flb_detect_type;

    flb_detect_type q, d;
    logic same, run_err, comma_hit, err;

    // ==========================================================
    // next state, one serial bit per pclk
    always_comb begin
        d = q;
        same = (bit_in == q.prev_bit);
        run_err = same && (q.run_cnt >= FLB_RUN_LIMIT);
        d.prev_bit = bit_in;
        if (!same) begin
            d.run_cnt = 3'h1;
        end else if (q.run_cnt != 3'h7) begin
            d.run_cnt = q.run_cnt + 3'h1;
        end
        // window slides one bit each cycle, so any alignment is caught
        d.shift = {q.shift[5:0], bit_in};
        comma_hit = (d.shift == FLB_COMMA_POS) || (d.shift == FLB_COMMA_NEG);
        d.run_seen = q.run_seen | run_err;
        d.comma_seen = q.comma_seen | comma_hit;
        err = d.run_seen | ~d.comma_seen;
        if (q.ivl_cnt == LAST) begin
            // interval boundary: latch and restart the accumulators
            d.ivl_cnt = '0;
            d.last_err = err;
            d.run_seen = 1'b0;
            d.comma_seen = 1'b0;
            if (!error_mode_pick) begin
                // single interval mode follows each result directly
                d.state = err ? FLB_LINK_BAD : FLB_LINK_GOOD;
                d.consec = 3'h0;
            end else if ((q.state == FLB_LINK_BAD) != err) begin
                // multiple interval mode needs a run against the state
                d.consec = q.consec + 3'h1;
                if (d.consec == FLB_CONSEC_N) begin
                    d.state = err ? FLB_LINK_BAD : FLB_LINK_GOOD;
                    d.consec = 3'h0;
                end
            end else begin
                d.consec = 3'h0;
            end
        end else begin
            d.ivl_cnt = q.ivl_cnt + CW'(1);
        end
        d.bad_n = (d.state != FLB_LINK_BAD);
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{prev_bit: 1'b0, run_cnt: 3'h0, shift: 7'h00, ivl_cnt: '0,
                   run_seen: 1'b0, comma_seen: 1'b0, last_err: 1'b0,
                   state: FLB_LINK_GOOD, consec: 3'h0, bad_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign link_bad_n = q.bad_n;
    assign interval_err = q.last_err;
endmodule // flb_signal_detect
`default_nettype wire

// ### rtl/flb_loop_top.sv
// Behaviour
// - stage always forwards loop input to drive
// - insert select high: drive input enters loop
// - insert select low: previous stage passes through
// - second steer: stage six or repeater two
// - first steer: repeater one or second steer
// - rate select high: reference times ten
// - rate select low: reference times twenty
// - repeaters retime on recovered clock
// - no incoming data: repeater locks to reference
// - more than five identical bits is error
// - missing comma in interval is error
// - intervals are 2^15 bit times back to back
// - errors latched at each interval boundary
// - one mode pick sets both detect units
// - single mode: fail right after errored interval
// - single mode: release after clean interval
// - multiple mode: four intervals to change state
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// loop routing, repeaters and link quality, apb control
module flb_loop_top #(
    parameter int unsigned INTERVAL_BITS = flb_pkg::FLB_INTERVAL_BITS,
    parameter int unsigned NUM_STAGES = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flb_pkg::FLB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_clock_in,
    input wire logic first_port_serial_rx,
    input wire logic second_port_serial_rx,
    output logic first_port_serial_tx,
    output logic second_port_serial_tx,
    input wire logic [NUM_STAGES-1:0] drive_serial_in,
    input wire logic [NUM_STAGES-1:0] drive_insert_select,
    output logic [NUM_STAGES-1:0] drive_serial_out,
    output logic [1:0] link_bad_n
);
    import flb_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [FLB_CTRL_W-1:0] ctrl; // mode, steering and rate controls
        logic [1:0] retimed; // repeater outputs, index 0 is the first port
        logic [1:0][6:0] quiet_cnt; // bit times since the last transition
        logic [1:0] on_ref; // repeater running from the reference
        logic second_steer; // second port steering result
        logic ref_prev; // reference level one cycle ago
        logic [4:0] ref_cnt; // bit times since the last rising reference edge
        logic ref_ok; // last reference period matched the ratio
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } flb_top_type;

    flb_top_type q, d;

    // ==========================================================
    // wiring between stages and detect units
    logic [NUM_STAGES:0] chain; // loop path through the stages
    logic [1:0] bad_n; // detect unit failure outputs
    logic [1:0] ivl_err; // detect unit interval results
    logic [1:0] rx; // both incoming serial streams
    logic [4:0] ratio; // expected bit times per reference period
    logic ref_rise;
    logic mode_pick, first_ctl, second_ctl, rate_sel;
    logic setup, access, hit_ctrl, hit_status;
    logic [31:0] status_word;

    assign rx = {second_port_serial_rx, first_port_serial_rx};
    assign mode_pick = q.ctrl[FLB_CTRL_MODE_BIT];
    assign first_ctl = q.ctrl[FLB_CTRL_P1_BIT];
    assign second_ctl = q.ctrl[FLB_CTRL_P2_BIT];
    assign rate_sel = q.ctrl[FLB_CTRL_RATE_BIT];

    // first steering mux feeds stage one straight from flops
    assign chain[0] = first_ctl ? q.retimed[0] : q.second_steer;

    // ==========================================================
    // bypass stages, one per attached drive
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STAGES; gi = gi + 1) begin : g_stage
            flb_bypass_stage u_stage (
                .pclk(pclk),
                .presetn(presetn),
                .loop_in(chain[gi]),
                .drive_serial_in(drive_serial_in[gi]),
                .drive_insert_select(drive_insert_select[gi]),
                .drive_serial_out(drive_serial_out[gi]),
                .loop_out(chain[gi+1])
            );
        end
    endgenerate

    // ==========================================================
    // signal detect units, each watching only its own repeater
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_detect
            flb_signal_detect #(
                .INTERVAL_BITS(INTERVAL_BITS)
            ) u_detect (
                .pclk(pclk),
                .presetn(presetn),
                .bit_in(q.retimed[gi]),
                .error_mode_pick(mode_pick),
                .link_bad_n(bad_n[gi]),
                .interval_err(ivl_err[gi])
            );
        end
    endgenerate

    // ==========================================================
    // status word seen by software
    always_comb begin
        status_word = '0;
        status_word[FLB_ST_BAD_LSB +: 2] = bad_n;
        status_word[FLB_ST_ERR_LSB +: 2] = ivl_err;
        status_word[FLB_ST_REF_LSB +: 2] = q.on_ref;
        status_word[FLB_ST_RATE_BIT] = q.ref_ok;
    end

    // apb phase and address decode
    assign setup = psel && !penable;
    assign access = psel && penable && q.ready;
    assign hit_ctrl = (paddr == FLB_CTRL_OFS);
    assign hit_status = (paddr == FLB_STATUS_OFS);

    // reference edge detect; the input is taken as synchronous
    assign ref_rise = reference_clock_in && !q.ref_prev;
    assign ratio = rate_sel ? FLB_RATIO_HIGH : FLB_RATIO_LOW;

    // ==========================================================
    // next state
    always_comb begin
        d = q;

        // repeaters: one bit per pclk stands in for the recovered bit clock,
        // so the data is retimed on the stream, never on the reference
        for (int k = 0; k < 2; k++) begin
            d.retimed[k] = rx[k];
            if (rx[k] != q.retimed[k]) begin
                // a transition means data is present again
                d.quiet_cnt[k] = 7'h00;
                d.on_ref[k] = 1'b0;
            end else if (q.quiet_cnt[k] == FLB_QUIET_BITS) begin
                // silent line: fall back on the reference with no outside help
                d.on_ref[k] = 1'b1;
            end else begin
                d.quiet_cnt[k] = q.quiet_cnt[k] + 7'h01;
            end
        end

        // second steering mux: low passes stage six, high repeater two
        d.second_steer = second_ctl ? q.retimed[1] : chain[NUM_STAGES];

        // bit clock multiplier check: count bit times per reference period;
        // a wrong rate select shows here, it cannot be corrected by the block
        d.ref_prev = reference_clock_in;
        if (ref_rise) begin
            d.ref_ok = (q.ref_cnt + 5'h01 == ratio);
            d.ref_cnt = 5'h00;
        end else if (q.ref_cnt != 5'h1F) begin
            d.ref_cnt = q.ref_cnt + 5'h01;
        end

        // apb: ready is raised for exactly the access phase after setup,
        // giving every transfer one wait-free access cycle
        d.ready = setup;
        if (setup) begin
            d.slverr = !(hit_ctrl || hit_status);
            if (hit_ctrl) begin
                d.rdata = {{(32 - FLB_CTRL_W){1'b0}}, q.ctrl};
            end else if (hit_status) begin
                d.rdata = status_word;
            end else begin
                // unmapped address reads zero and reports an error
                d.rdata = 32'h0000_0000;
            end
        end else if (access) begin
            // answer ends with the access phase
            d.slverr = 1'b0;
            if (pwrite && hit_ctrl) begin
                d.ctrl = pwdata[FLB_CTRL_W-1:0];
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{ctrl: FLB_CTRL_RST, retimed: 2'h0, quiet_cnt: '0,
                   on_ref: 2'h3, second_steer: 1'b0, ref_prev: 1'b0,
                   ref_cnt: 5'h00, ref_ok: 1'b0, rdata: 32'h0000_0000,
                   ready: 1'b0, slverr: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs, all from flops
    assign first_port_serial_tx = q.second_steer;
    assign second_port_serial_tx = chain[NUM_STAGES];
    assign link_bad_n = bad_n;
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr;
endmodule // flb_loop_top
`default_nettype wire

// ### verif/flb_loop_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker: stage chain, apb answer, detect output timing
module flb_loop_top_checker #(
    parameter int unsigned INTERVAL_BITS = flb_pkg::FLB_INTERVAL_BITS,
    parameter int unsigned NUM_STAGES = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic second_port_serial_tx,
    input wire logic [NUM_STAGES-1:0] drive_serial_in,
    input wire logic [NUM_STAGES-1:0] drive_insert_select,
    input wire logic [NUM_STAGES-1:0] drive_serial_out,
    input wire logic [1:0] link_bad_n
);
    // position in the free running interval, counted from reset release
    logic [31:0] pos_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 32'h0;
        end else begin
            pos_q <= (pos_q == INTERVAL_BITS - 1) ? 32'h0 : pos_q + 32'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // stage chain: each stage output shows on the next drive output
    for (genvar k = 0; k < 5; k++) begin : g_stage
        property p_ins;
            drive_insert_select[k] |-> ##2 drive_serial_out[k+1] == $past(drive_serial_in[k], 2);
        endproperty
        a_ins: assert property (p_ins) else $error("inserted drive bit lost");
        property p_byp;
            !drive_insert_select[k] |-> ##2 drive_serial_out[k+1] == $past(drive_serial_out[k]);
        endproperty
        a_byp: assert property (p_byp) else $error("bypassed stage lost loop bit");
    end
    // ==========================================================
    // last stage feeds the second port
    property p_tx2_ins;
        drive_insert_select[5] |=> second_port_serial_tx == $past(drive_serial_in[5]);
    endproperty
    a_tx2_ins: assert property (p_tx2_ins) else $error("drive six not on port two");
    property p_tx2_fwd;
        !drive_insert_select[5] |=> second_port_serial_tx == drive_serial_out[5];
    endproperty
    a_tx2_fwd: assert property (p_tx2_fwd) else $error("port two lost loop bit");
    // ==========================================================
    // apb: one access cycle, answer only in an access phase
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_ready_src;
        pready |-> psel && penable && $past(psel && !penable);
    endproperty
    a_ready_src: assert property (p_ready_src) else $error("answer outside access phase");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without answer");
    // failure outputs move only just after a boundary
    property p_bad_win;
        $changed(link_bad_n) |-> pos_q < 32'h4 || pos_q > INTERVAL_BITS - 4;
    endproperty
    a_bad_win: assert property (p_bad_win) else $error("failure moved mid interval");
    c_insert: cover property (drive_insert_select[5] && drive_serial_in[5]);
    c_refuse: cover property (pready && pslverr);
    c_fail: cover property ($fell(link_bad_n[1]));
    c_release: cover property ($rose(link_bad_n[1]));
endmodule // flb_loop_top_checker
bind flb_loop_top flb_loop_top_checker #(
    .INTERVAL_BITS(INTERVAL_BITS), .NUM_STAGES(NUM_STAGES)
) i_flb_loop_top_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .second_port_serial_tx(second_port_serial_tx),
    .drive_serial_in(drive_serial_in), .drive_insert_select(drive_insert_select),
    .drive_serial_out(drive_serial_out), .link_bad_n(link_bad_n)
);
`default_nettype wire

// ### verif/flb_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: loop devices on both ports and the reference oscillator
module flb_link_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rate_high,
    input wire logic [1:0] mode1,
    input wire logic [1:0] mode2,
    output logic first_port_serial_rx,
    output logic second_port_serial_rx,
    output logic reference_clock_in
);
    // idle word: comma every ten bits, longest run exactly five
    localparam logic [9:0] IDLE_WORD = 10'h0FA;
    logic [3:0] bit_q; // position in the idle word
    logic [4:0] ref_q; // half period count of the reference
    logic alt_q; // toggles each bit: no long run, but never a comma
    // mode 0 idle stream, 1 stuck high, 2 toggling, 3 stuck low
    function automatic logic stream_bit(input logic [1:0] m, input logic [3:0] b, input logic a);
        case (m)
            2'h0: return IDLE_WORD[4'h9 - b];
            2'h1: return 1'b1;
            2'h2: return a;
            default: return 1'b0;
        endcase
    endfunction
    // bit position, toggle and reference all advance on pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_q <= 4'h0;
            ref_q <= 5'h0;
            alt_q <= 1'b0;
            reference_clock_in <= 1'b0;
        end else begin
            bit_q <= (bit_q == 4'h9) ? 4'h0 : bit_q + 4'h1;
            alt_q <= ~alt_q;
            // half period of five or ten bit times, as the system claims
            if (ref_q >= (rate_high ? 5'h4 : 5'h9)) begin
                ref_q <= 5'h0;
                reference_clock_in <= ~reference_clock_in;
            end else begin
                ref_q <= ref_q + 5'h1;
            end
        end
    end
    assign first_port_serial_rx = stream_bit(mode1, bit_q, alt_q);
    assign second_port_serial_rx = stream_bit(mode2, bit_q, alt_q);
endmodule // flb_link_partner
`default_nettype wire

// ### verif/fcal_loop_bypass_signal_detect_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench: queued apb notes, steady loop levels, detect outputs
module fcal_loop_bypass_signal_detect_test;
    import flb_pkg::*;
    localparam int unsigned IB = 64; // short interval keeps the run brief
    // {ctl, mode1, mode2, insert6, drive6, tx1, tx2}
    localparam logic [11:0] ROUTE_TAB [4] = '{12'hA73, 12'hE71, 12'hADF, 12'hC70};
    // {multiple, mode1, mode2, half intervals, link_bad_n}
    localparam logic [10:0] DET_TAB [9] = '{11'h055, 11'h017, 11'h216, 11'h017, 11'h40B,
        11'h457, 11'h459, 11'h415, 11'h41B};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [FLB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ref_clk, rx1, rx2, tx1, tx2, rate_high, dsi5;
    logic [5:0] dsi, sel, dso;
    logic [1:0] bad_n, m1, m2;
    logic [64:0] expq[$]; // apb notes: {error, compare mask, data}
    int n_errors, samples_checked, cycles;
    integer seed;
    flb_loop_top #(.INTERVAL_BITS(IB)) i_flb_loop_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock_in(ref_clk), .first_port_serial_rx(rx1), .second_port_serial_rx(rx2),
        .first_port_serial_tx(tx1), .second_port_serial_tx(tx2), .drive_serial_in(dsi),
        .drive_insert_select(sel), .drive_serial_out(dso), .link_bad_n(bad_n));
    flb_link_partner i_flb_link_partner (
        .pclk(pclk), .presetn(presetn), .rate_high(rate_high), .mode1(m1), .mode2(m2),
        .first_port_serial_rx(rx1), .second_port_serial_rx(rx2), .reference_clock_in(ref_clk));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; the monitor compares the answer with the note
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic e);
        int t;
        t = 0;
        expq.push_back({e, m, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 40);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // wait, optionally scrambling the insert selects each bit
    task automatic waitc(input int n, input logic r);
        repeat (n) begin
            @(posedge pclk);
            if (r) begin
                sel <= 6'($random(seed));
            end
        end
    endtask
    // drives one to five carry random data, drive six is set by the tests
    always @(posedge pclk) begin
        dsi <= {dsi5, 5'($random(seed))};
    end
    // takes the oldest note whenever the slave answers
    always @(posedge pclk) begin : apb_monitor
        logic [64:0] n;
        if (presetn && psel && penable && pready === 1'b1 && expq.size() > 0) begin
            n = expq.pop_front();
            chk("pslverr", {31'h0, n[64]}, {31'h0, pslverr});
            if (n[63:32] != 32'h0) begin
                chk("prdata", n[31:0] & n[63:32], prdata & n[63:32]);
            end
        end
    end
    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            $display("[FAIL] run length expected under 6000 seen %0d", cycles);
            finish_test();
        end
    end
    initial begin
        seed = 32'h3bdb;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dsi5 = 1'b0;
        sel = 6'h00;
        m1 = 2'h0;
        m2 = 2'h0;
        rate_high = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, FLB_CTRL_OFS, 32'h8, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, FLB_STATUS_OFS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, FLB_STATUS_OFS, 32'h3, 32'hF, 1'b0);
        apb(1'b1, 12'h008, 32'h5, 32'h0, 1'b1);
        apb(1'b0, 12'h008, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, FLB_CTRL_OFS, 32'hFFFFFFF2, 32'h0, 1'b0);
        apb(1'b0, FLB_CTRL_OFS, 32'h2, 32'hFFFFFFFF, 1'b0);
        $display("test registers done");
        foreach (ROUTE_TAB[i]) begin
            apb(1'b1, FLB_CTRL_OFS, {28'h0, ROUTE_TAB[i][11:8]}, 32'h0, 1'b0);
            m1 <= ROUTE_TAB[i][7:6];
            m2 <= ROUTE_TAB[i][5:4];
            sel <= {ROUTE_TAB[i][3], 5'h00};
            dsi5 <= ROUTE_TAB[i][2];
            waitc(20, 1'b0);
            chk("tx1", {31'h0, ROUTE_TAB[i][1]}, {31'h0, tx1});
            chk("tx2", {31'h0, ROUTE_TAB[i][0]}, {31'h0, tx2});
        end
        $display("test routing done");
        foreach (DET_TAB[i]) begin
            apb(1'b1, FLB_CTRL_OFS, {28'h0, 3'h5, DET_TAB[i][10]}, 32'h0, 1'b0);
            m1 <= DET_TAB[i][9:8];
            m2 <= DET_TAB[i][7:6];
            waitc(DET_TAB[i][5:2] * IB / 2, 1'b1);
            chk("link_bad_n", {30'h0, DET_TAB[i][1:0]}, {30'h0, bad_n});
            if (i == 0) begin
                apb(1'b0, FLB_STATUS_OFS, 32'h28, 32'h3C, 1'b0);
            end
        end
        $display("test detect done");
        apb(1'b0, FLB_STATUS_OFS, 32'h40, 32'h40, 1'b0);
        apb(1'b1, FLB_CTRL_OFS, 32'h2, 32'h0, 1'b0);
        waitc(60, 1'b0);
        apb(1'b0, FLB_STATUS_OFS, 32'h0, 32'h40, 1'b0);
        rate_high <= 1'b0;
        waitc(60, 1'b0);
        apb(1'b0, FLB_STATUS_OFS, 32'h40, 32'h40, 1'b0);
        $display("test rate done");
        finish_test();
    end
endmodule // fcal_loop_bypass_signal_detect_test
`default_nettype wire
